/* core/insn_timing_pkg.sv */
// package of widths, encodings and per-cycle state costs for the instruction timing model
package insn_timing_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int COUNT_W = 4;
   localparam int WAIT_W = 3;
   localparam int COST_W = 5;
   localparam int TOTAL_W = 12;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [TOTAL_W-1:0] STATES_RESET = 12'h000;
   localparam logic DONE_RESET = 1'b0;

   // ****************************************
   // state cost of one cycle, by target
   // ****************************************
   localparam logic [COST_W-1:0] COST_ONCHIP_MEM = 5'h02;
   localparam logic [COST_W-1:0] COST_INTERNAL = 5'h01;
   localparam logic [COST_W-1:0] COST_SUP8_WORD = 5'h06;
   localparam logic [COST_W-1:0] COST_SUP8_BYTE = 5'h03;
   localparam logic [COST_W-1:0] COST_SUP16 = 5'h03;
   localparam logic [COST_W-1:0] COST_EXT8_2S_WORD = 5'h04;
   localparam logic [COST_W-1:0] COST_EXT8_2S_BYTE = 5'h02;
   localparam logic [COST_W-1:0] COST_EXT8_3S_WORD_BASE = 5'h06;
   localparam logic [COST_W-1:0] COST_EXT8_3S_BYTE_BASE = 5'h03;
   localparam logic [COST_W-1:0] COST_EXT16_2S = 5'h02;
   localparam logic [COST_W-1:0] COST_EXT16_3S_BASE = 5'h03;

   // ****************************************
   // cycle counts of the built-in instruction forms
   // ****************************************
   localparam logic [COUNT_W-1:0] FETCH_IMM8 = 4'h1;
   localparam logic [COUNT_W-1:0] FETCH_IMM16 = 4'h2;
   localparam logic [COUNT_W-1:0] FETCH_IMM32 = 4'h3;
   localparam logic [COUNT_W-1:0] FETCH_REG = 4'h1;
   localparam logic [COUNT_W-1:0] BITSET_FETCH = 4'h2;
   localparam logic [COUNT_W-1:0] BITSET_BYTE = 4'h2;
   localparam logic [COUNT_W-1:0] CALL_FETCH = 4'h2;
   localparam logic [COUNT_W-1:0] CALL_BRANCH = 4'h2;
   localparam logic [COUNT_W-1:0] CALL_STACK = 4'h2;
   localparam logic [COUNT_W-1:0] COUNT_NONE = 4'h0;

   // ****************************************
   // enumerations
   // ****************************************
   typedef enum logic [2:0] {
      region_onchip_mem,
      region_sup_8bit,
      region_sup_16bit,
      region_ext8_2state,
      region_ext8_3state,
      region_ext16_2state,
      region_ext16_3state,
      region_spare
   } region_e;

   typedef enum logic [3:0] {
      insn_add_b_imm,
      insn_add_b_reg,
      insn_add_w_imm,
      insn_add_w_reg,
      insn_add_l_imm,
      insn_add_l_reg,
      insn_bit_set_insn_abs8,
      insn_subroutine_call_insn_indirect,
      insn_custom_counts
   } insn_e;

endpackage

/* core/cycle_cost.sv */
// state cost of one bus cycle for a given target region and access size
`timescale 1ns/1ps
`default_nettype none
module cycle_cost (
   // target
   input wire insn_timing_pkg::region_e region_in,
   input wire logic byte_access_in,
   input wire logic [insn_timing_pkg::WAIT_W-1:0] wait_states_in,
   // result
   output logic [insn_timing_pkg::COST_W-1:0] cost_out
);

   logic [insn_timing_pkg::COST_W-1:0] wait_one;
   logic [insn_timing_pkg::COST_W-1:0] wait_two;

   assign wait_one = {2'h0, wait_states_in};
   assign wait_two = {1'h0, wait_states_in, 1'h0};

   // ****************************************
   // cost lookup
   // ****************************************
   always_comb begin
      cost_out = insn_timing_pkg::COST_ONCHIP_MEM;
      unique case (region_in)
         insn_timing_pkg::region_onchip_mem: cost_out = insn_timing_pkg::COST_ONCHIP_MEM;
         insn_timing_pkg::region_sup_8bit: cost_out = byte_access_in ? insn_timing_pkg::COST_SUP8_BYTE
                                                                     : insn_timing_pkg::COST_SUP8_WORD;
         insn_timing_pkg::region_sup_16bit: cost_out = insn_timing_pkg::COST_SUP16;
         insn_timing_pkg::region_ext8_2state: cost_out = byte_access_in ? insn_timing_pkg::COST_EXT8_2S_BYTE
                                                                        : insn_timing_pkg::COST_EXT8_2S_WORD;
         // two bytes on an 8-bit bus pay the wait states twice
         insn_timing_pkg::region_ext8_3state: cost_out = byte_access_in
            ? insn_timing_pkg::COST_EXT8_3S_BYTE_BASE + wait_one
            : insn_timing_pkg::COST_EXT8_3S_WORD_BASE + wait_two;
         insn_timing_pkg::region_ext16_2state: cost_out = insn_timing_pkg::COST_EXT16_2S;
         insn_timing_pkg::region_ext16_3state: cost_out = insn_timing_pkg::COST_EXT16_3S_BASE + wait_one;
         // the spare code is treated as on-chip memory
         insn_timing_pkg::region_spare: cost_out = insn_timing_pkg::COST_ONCHIP_MEM;
      endcase
   end

endmodule // cycle_cost
`default_nettype wire

/* core/insn_state_counter.sv */
// instruction execution state counter: cycle counts weighted by per-cycle state costs
`timescale 1ns/1ps
`default_nettype none
module insn_state_counter (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // request
   input wire logic start_in,
   input wire insn_timing_pkg::insn_e insn_in,
   // counts used by the custom form
   input wire logic [insn_timing_pkg::COUNT_W-1:0] fetch_count_in,
   input wire logic [insn_timing_pkg::COUNT_W-1:0] branch_count_in,
   input wire logic [insn_timing_pkg::COUNT_W-1:0] stack_count_in,
   input wire logic [insn_timing_pkg::COUNT_W-1:0] byte_count_in,
   input wire logic [insn_timing_pkg::COUNT_W-1:0] word_count_in,
   input wire logic [insn_timing_pkg::COUNT_W-1:0] internal_count_in,
   // bus configuration
   input wire insn_timing_pkg::region_e region_fetch_in,
   input wire insn_timing_pkg::region_e region_branch_in,
   input wire insn_timing_pkg::region_e region_stack_in,
   input wire insn_timing_pkg::region_e region_data_in,
   input wire logic [insn_timing_pkg::WAIT_W-1:0] wait_states_in,
   // result
   output logic [insn_timing_pkg::TOTAL_W-1:0] states_out,
   output logic done_out
);

   localparam int NK = 6;
   localparam int TOTAL_W = insn_timing_pkg::TOTAL_W;

   logic [insn_timing_pkg::COUNT_W-1:0] cnt [NK];
   logic [insn_timing_pkg::COST_W-1:0] cost [NK];
   logic [insn_timing_pkg::TOTAL_W-1:0] term [NK];
   logic [insn_timing_pkg::TOTAL_W-1:0] states_next;
   logic [insn_timing_pkg::TOTAL_W-1:0] states_reg;
   logic done_reg;

   // ****************************************
   // cycle counts per instruction form
   // ****************************************
   always_comb begin
      for (int k = 0; k < NK; k++) begin
         cnt[k] = insn_timing_pkg::COUNT_NONE;
      end
      unique case (insn_in)
         insn_timing_pkg::insn_add_b_imm: cnt[0] = insn_timing_pkg::FETCH_IMM8;
         insn_timing_pkg::insn_add_b_reg: cnt[0] = insn_timing_pkg::FETCH_REG;
         insn_timing_pkg::insn_add_w_imm: cnt[0] = insn_timing_pkg::FETCH_IMM16;
         insn_timing_pkg::insn_add_w_reg: cnt[0] = insn_timing_pkg::FETCH_REG;
         insn_timing_pkg::insn_add_l_imm: cnt[0] = insn_timing_pkg::FETCH_IMM32;
         insn_timing_pkg::insn_add_l_reg: cnt[0] = insn_timing_pkg::FETCH_REG;
         insn_timing_pkg::insn_bit_set_insn_abs8: begin
            cnt[0] = insn_timing_pkg::BITSET_FETCH;
            cnt[3] = insn_timing_pkg::BITSET_BYTE;
         end
         insn_timing_pkg::insn_subroutine_call_insn_indirect: begin
            cnt[0] = insn_timing_pkg::CALL_FETCH;
            cnt[1] = insn_timing_pkg::CALL_BRANCH;
            cnt[2] = insn_timing_pkg::CALL_STACK;
         end
         insn_timing_pkg::insn_custom_counts: begin
            cnt[0] = fetch_count_in;
            cnt[1] = branch_count_in;
            cnt[2] = stack_count_in;
            cnt[3] = byte_count_in;
            cnt[4] = word_count_in;
            cnt[5] = internal_count_in;
         end
         // unused codes count nothing
         default: cnt[0] = insn_timing_pkg::COUNT_NONE;
      endcase
   end

   // ****************************************
   // per-kind state cost
   // ****************************************
   cycle_cost u_cost_fetch (
      .region_in(region_fetch_in),
      .byte_access_in(1'b0),
      .wait_states_in(wait_states_in),
      .cost_out(cost[0])
   );
   cycle_cost u_cost_branch (
      .region_in(region_branch_in),
      .byte_access_in(1'b0),
      .wait_states_in(wait_states_in),
      .cost_out(cost[1])
   );
   cycle_cost u_cost_stack (
      .region_in(region_stack_in),
      .byte_access_in(1'b0),
      .wait_states_in(wait_states_in),
      .cost_out(cost[2])
   );
   cycle_cost u_cost_byte (
      .region_in(region_data_in),
      .byte_access_in(1'b1),
      .wait_states_in(wait_states_in),
      .cost_out(cost[3])
   );
   cycle_cost u_cost_word (
      .region_in(region_data_in),
      .byte_access_in(1'b0),
      .wait_states_in(wait_states_in),
      .cost_out(cost[4])
   );
   // internal cycles never touch a bus, so the configuration cannot change them
   assign cost[5] = insn_timing_pkg::COST_INTERNAL;

   // ****************************************
   // weighted sum
   // ****************************************
   // worst case 6 x 15 x 20 fits in 12 bits, so the sum cannot wrap
   always_comb begin
      states_next = insn_timing_pkg::STATES_RESET;
      for (int k = 0; k < NK; k++) begin
         term[k] = TOTAL_W'(cnt[k]) * TOTAL_W'(cost[k]);
         states_next = states_next + term[k];
      end
   end

   // ****************************************
   // result registers
   // ****************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         states_reg <= insn_timing_pkg::STATES_RESET;
      end else if (start_in) begin
         states_reg <= states_next;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         done_reg <= insn_timing_pkg::DONE_RESET;
      end else begin
         done_reg <= start_in;
      end
   end

   assign states_out = states_reg;
   assign done_out = done_reg;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   logic all_onchip;
   assign all_onchip = region_fetch_in == insn_timing_pkg::region_onchip_mem
                    && region_branch_in == insn_timing_pkg::region_onchip_mem
                    && region_stack_in == insn_timing_pkg::region_onchip_mem
                    && region_data_in == insn_timing_pkg::region_onchip_mem;

   a_done_follows_start: assert property (start_in |=> done_out ##1 (done_out == $past(start_in)))
      else $error("done does not follow start by one cycle");

   a_custom_onchip_sum: assert property (start_in && insn_in == insn_timing_pkg::insn_custom_counts && all_onchip
      |=> states_out == 12'h002 * ($past(12'(fetch_count_in)) + $past(12'(branch_count_in))
                                   + $past(12'(stack_count_in)) + $past(12'(byte_count_in))
                                   + $past(12'(word_count_in))) + $past(12'(internal_count_in)))
      else $error("custom on-chip total is wrong");

   a_internal_fixed: assert property (start_in && insn_in == insn_timing_pkg::insn_custom_counts
      && fetch_count_in == 4'h0 && branch_count_in == 4'h0 && stack_count_in == 4'h0
      && byte_count_in == 4'h0 && word_count_in == 4'h0
      |=> states_out == $past(12'(internal_count_in)))
      else $error("internal cycles are not one state each");

   a_width_matters: assert property (start_in && insn_in == insn_timing_pkg::insn_add_b_reg
      && region_fetch_in == insn_timing_pkg::region_sup_8bit |=> states_out == 12'h006)
      else $error("8-bit module fetch is not 6 states");

   a_wait_ext8: assert property (start_in && insn_in == insn_timing_pkg::insn_add_w_reg
      && region_fetch_in == insn_timing_pkg::region_ext8_3state
      |=> states_out == 12'h006 + 12'h002 * $past(12'(wait_states_in)))
      else $error("8-bit three-state fetch ignores waits");

   a_wait_byte: assert property (start_in && insn_in == insn_timing_pkg::insn_bit_set_insn_abs8
      && region_fetch_in == insn_timing_pkg::region_onchip_mem
      && region_data_in == insn_timing_pkg::region_ext16_3state
      |=> states_out == 12'h004 + 12'h002 * (12'h003 + $past(12'(wait_states_in))))
      else $error("byte wait cost is wrong");

   a_add_imm_fetch: assert property (start_in && insn_in == insn_timing_pkg::insn_add_l_imm && all_onchip
      |=> states_out == 12'h006)
      else $error("32-bit immediate add is not three fetches");

   a_bitset_example: assert property (start_in && insn_in == insn_timing_pkg::insn_bit_set_insn_abs8
      && region_fetch_in == insn_timing_pkg::region_ext16_3state && wait_states_in == 3'h1
      && region_data_in == insn_timing_pkg::region_sup_8bit |=> states_out == 12'h00e)
      else $error("bit set example total is not 14");

   a_call_example: assert property (start_in && insn_in == insn_timing_pkg::insn_subroutine_call_insn_indirect
      && region_fetch_in == insn_timing_pkg::region_ext16_3state
      && region_branch_in == insn_timing_pkg::region_ext16_3state
      && region_stack_in == insn_timing_pkg::region_ext16_3state && wait_states_in == 3'h1
      |=> states_out == 12'h018)
      else $error("call example total is not 24");

   a_hold_idle: assert property (!start_in |=> $stable(states_out))
      else $error("result changed without a request");

   c_bitset: cover property (start_in && insn_in == insn_timing_pkg::insn_bit_set_insn_abs8 ##1 done_out);
   c_call: cover property (start_in && insn_in == insn_timing_pkg::insn_subroutine_call_insn_indirect ##1 done_out);
   c_custom_wait: cover property (start_in && insn_in == insn_timing_pkg::insn_custom_counts
      && wait_states_in != 3'h0 ##1 done_out);
   c_back_to_back: cover property (start_in ##1 start_in ##1 done_out);

endmodule // insn_state_counter
`default_nettype wire

/* tb/bus_target_model.sv */
// far-side timing model: state cost of one cycle at each bus target
`timescale 1ns/1ps
`default_nettype none
module bus_target_model (
   // targets
   input wire insn_timing_pkg::region_e region_fetch_in,
   input wire insn_timing_pkg::region_e region_branch_in,
   input wire insn_timing_pkg::region_e region_stack_in,
   input wire insn_timing_pkg::region_e region_data_in,
   input wire logic [insn_timing_pkg::WAIT_W-1:0] wait_states_in,
   // costs
   output logic [insn_timing_pkg::COST_W-1:0] fetch_cost_out,
   output logic [insn_timing_pkg::COST_W-1:0] branch_cost_out,
   output logic [insn_timing_pkg::COST_W-1:0] stack_cost_out,
   output logic [insn_timing_pkg::COST_W-1:0] byte_cost_out,
   output logic [insn_timing_pkg::COST_W-1:0] word_cost_out
);
   // ****************************************
   // cost of one cycle
   // ****************************************
   // fetch, branch and stack cycles move words, so they cost as word accesses
   function automatic logic [4:0] cost(input logic [2:0] r, input logic b, input logic [4:0] m);
      case (r)
         3'h1: cost = b ? 5'h03 : 5'h06;
         3'h2: cost = 5'h03;
         3'h3: cost = b ? 5'h02 : 5'h04;
         3'h4: cost = b ? 5'h03 + m : 5'h06 + m + m;
         3'h5: cost = 5'h02;
         3'h6: cost = 5'h03 + m;
         default: cost = 5'h02;
      endcase
   endfunction

   assign fetch_cost_out = cost(region_fetch_in, 1'b0, {2'h0, wait_states_in});
   assign branch_cost_out = cost(region_branch_in, 1'b0, {2'h0, wait_states_in});
   assign stack_cost_out = cost(region_stack_in, 1'b0, {2'h0, wait_states_in});
   assign byte_cost_out = cost(region_data_in, 1'b1, {2'h0, wait_states_in});
   assign word_cost_out = cost(region_data_in, 1'b0, {2'h0, wait_states_in});
endmodule // bus_target_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the instruction state counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ****************************************
   // signals
   // ****************************************
   typedef struct packed {
      logic [3:0] insn;
      logic [2:0] rf, rb, rs, rd, w;
      logic [23:0] counts;
      logic [11:0] exp;
   } row_s;
   logic clk_sys, rst, start, done;
   insn_timing_pkg::insn_e insn;
   insn_timing_pkg::region_e reg_f, reg_b, reg_s, reg_d;
   logic [3:0] c_f, c_b, c_s, c_l, c_m, c_n;
   logic [2:0] wait_states;
   logic [11:0] states, exp_sum;
   logic [4:0] k_f, k_b, k_s, k_l, k_m;
   int n_mismatch = 0;
   int num_checks = 0;
   // regions: 0 onchip 1 sup8 2 sup16 3 ext8_2s 4 ext8_3s 5 ext16_2s 6 ext16_3s 7 spare
   row_s rows [18] = '{
      '{4'h6, 3'h6, 3'h0, 3'h0, 3'h1, 3'h1, 24'hffffff, 12'h00e},
      '{4'h7, 3'h6, 3'h6, 3'h6, 3'h0, 3'h1, 24'h000000, 12'h018},
      '{4'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 24'h000000, 12'h002},
      '{4'h2, 3'h4, 3'h0, 3'h0, 3'h0, 3'h2, 24'h000000, 12'h014},
      '{4'h4, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 24'h000000, 12'h012},
      '{4'h5, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 24'h000000, 12'h004},
      '{4'h3, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 24'h000000, 12'h003},
      '{4'h1, 3'h5, 3'h0, 3'h0, 3'h0, 3'h0, 24'h000000, 12'h002},
      '{4'h8, 3'h0, 3'h3, 3'h2, 3'h4, 3'h3, 24'h111213, 12'h024},
      '{4'h6, 3'h0, 3'h0, 3'h0, 3'h4, 3'h7, 24'h000000, 12'h018},
      '{4'h8, 3'h7, 3'h0, 3'h0, 3'h3, 3'h0, 24'h100120, 12'h00c},
      '{4'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 24'h000000, 12'h006},
      '{4'h3, 3'h4, 3'h0, 3'h0, 3'h0, 3'h5, 24'h000000, 12'h010},
      '{4'h6, 3'h0, 3'h0, 3'h0, 3'h6, 3'h2, 24'h000000, 12'h00e},
      '{4'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 24'h000000, 12'h006},
      '{4'h8, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 24'h21304a, 12'h01e},
      '{4'h8, 3'h1, 3'h3, 3'h6, 3'h4, 3'h5, 24'h00000f, 12'h00f},
      '{4'h9, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 24'h111111, 12'h000}};

   insn_state_counter uut (.clk_sys_in(clk_sys), .rst_in(rst), .start_in(start), .insn_in(insn),
      .fetch_count_in(c_f), .branch_count_in(c_b), .stack_count_in(c_s), .byte_count_in(c_l),
      .word_count_in(c_m), .internal_count_in(c_n), .region_fetch_in(reg_f), .region_branch_in(reg_b),
      .region_stack_in(reg_s), .region_data_in(reg_d), .wait_states_in(wait_states),
      .states_out(states), .done_out(done));

   bus_target_model far_side (.region_fetch_in(reg_f), .region_branch_in(reg_b), .region_stack_in(reg_s),
      .region_data_in(reg_d), .wait_states_in(wait_states), .fetch_cost_out(k_f), .branch_cost_out(k_b),
      .stack_cost_out(k_s), .byte_cost_out(k_l), .word_cost_out(k_m));

   // ****************************************
   // tasks
   // ****************************************
   task automatic check_val(input string what, input logic [11:0] exp, input logic [11:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic drive(input row_s r, input logic go);
      insn = insn_timing_pkg::insn_e'(r.insn);
      reg_f = insn_timing_pkg::region_e'(r.rf);
      reg_b = insn_timing_pkg::region_e'(r.rb);
      reg_s = insn_timing_pkg::region_e'(r.rs);
      reg_d = insn_timing_pkg::region_e'(r.rd);
      {c_f, c_b, c_s, c_l, c_m, c_n} = r.counts;
      wait_states = r.w;
      start = go;
   endtask

   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ****************************************
   // clock, watchdog and main sequence
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // a hang costs a mismatch and ends the run through the same report
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_mismatch++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      drive(rows[2], 1'b0);
      repeat (8) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      check_val("states after reset", 12'h000, states);
      check_bit("done after reset", 1'b0, done);
      $display("test reset done");
      foreach (rows[i]) begin
         step();
         drive(rows[i], 1'b1);
         step();
         start = 1'b0;
         check_bit("done", 1'b1, done);
         check_val("states", rows[i].exp, states);
         step();
         check_bit("done pulse", 1'b0, done);
         check_val("states held", rows[i].exp, states);
      end
      $display("test table done");
      // every external cycle sees the same wait count
      for (int m = 0; m < 8; m++) begin
         step();
         drive('{4'h8, 3'h6, 3'h4, 3'h6, 3'h4, m[2:0], 24'h111111, 12'h000}, 1'b1);
         #1;
         exp_sum = 12'(k_f) + 12'(k_b) + 12'(k_s) + 12'(k_l) + 12'(k_m) + 12'h001;
         step();
         start = 1'b0;
         check_val("wait sweep", exp_sum, states);
         check_val("wait formula", 12'(22 + 7 * m), states);
      end
      $display("test wait sweep done");
      step();
      drive(rows[0], 1'b1);
      step();
      drive(rows[1], 1'b1);
      check_val("first of pair", 12'h00e, states);
      step();
      start = 1'b0;
      check_bit("done held", 1'b1, done);
      check_val("second of pair", 12'h018, states);
      step();
      check_bit("done drops", 1'b0, done);
      $display("test back to back done");
      rst = 1'b1;
      #1;
      check_val("states in reset", 12'h000, states);
      check_bit("done in reset", 1'b0, done);
      step();
      rst = 1'b0;
      drive(rows[2], 1'b1);
      step();
      start = 1'b0;
      check_val("first after reset", 12'h002, states);
      $display("test mid reset done");
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
